// ==== pkg/dww_cfg.svh ====
// constants of the display window write block
`ifndef DWW_CFG_SVH
`define DWW_CFG_SVH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define DWW_OFS_CMD 8'h00
`define DWW_OFS_PARAM 8'h04
`define DWW_OFS_PIXEL 8'h08
`define DWW_OFS_CTRL 8'h0c
`define DWW_OFS_STATUS 8'h10
`define DWW_OFS_COLWIN 8'h14
`define DWW_OFS_ROWWIN 8'h18
`define DWW_OFS_POS 8'h1c

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define DWW_CMD_SWRESET 8'h01
`define DWW_CMD_BLANK 8'h28
`define DWW_CMD_SHOW 8'h29
`define DWW_CMD_COLWIN 8'h2a
`define DWW_CMD_ROWWIN 8'h2b
`define DWW_CMD_PIXWR 8'h2c

// ----------------------------------------------------------------
// address limits and resolution codes
// ----------------------------------------------------------------
`define DWW_MAX_359 16'h0167
`define DWW_MAX_319 16'h013f
`define DWW_MAX_639 16'h027f
`define DWW_MAX_479 16'h01df
`define DWW_RES_360X640 2'b00
`define DWW_RES_360X480 2'b01
`define DWW_RES_320X480 2'b10

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define DWW_CTRL_RES_LO 0
`define DWW_CTRL_SWAP 2
`define DWW_CTRL_COLREV 3
`define DWW_CTRL_ROWREV 4
`define DWW_CTRL_SLEEP 5
`define DWW_CTRL_W 6
`define DWW_CTRL_RST 6'h00
`define DWW_STAT_SHOW 0
`define DWW_STAT_STREAM 1
`define DWW_STAT_DROP 2
`define DWW_PIDX_LAST 2'h3
`define DWW_ZERO16 16'h0000

`endif

// ==== pkg/dww_pkg.sv ====
// types of the display window write block
`include "dww_cfg.svh"
package dww_pkg;

    typedef enum logic [1:0] {
        DWW_IDLE,
        DWW_COLP,
        DWW_ROWP,
        DWW_PIX
    } dww_mode_type;

    typedef struct packed {
        logic [1:0] rs;
    } dww_rst_type;

    typedef struct packed {
        dww_mode_type mode;
        logic [1:0] pidx;
        logic show;
        logic [15:0] col_start;
        logic [15:0] col_end;
        logic [15:0] row_start;
        logic [15:0] row_end;
        logic [`DWW_CTRL_W-1:0] ctrl;
        logic [7:0] last_cmd;
        logic dropped;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic panel_blank;
        logic mem_we;
        logic [15:0] mem_col;
        logic [15:0] mem_row;
        logic [23:0] mem_data;
    } dww_top_type;

    typedef struct packed {
        logic [15:0] col;
        logic [15:0] row;
    } dww_gen_type;

endpackage

// ==== pkg/dww_win_if.sv ====
// window counter link between command logic and address generator
interface dww_win_if;
    logic load;
    logic step;
    logic [15:0] col_start;
    logic [15:0] col_end;
    logic [15:0] row_start;
    logic [15:0] row_end;
    logic col_rev;
    logic row_rev;
    logic swap;
    logic [1:0] res;
    logic [15:0] cur_col;
    logic [15:0] cur_row;
    logic [15:0] max_col;
    logic [15:0] max_row;
    logic in_range;

    modport ctl (
        output load, step, col_start, col_end, row_start, row_end,
        output col_rev, row_rev, swap, res,
        input cur_col, cur_row, max_col, max_row, in_range
    );
    modport gen (
        input load, step, col_start, col_end, row_start, row_end,
        input col_rev, row_rev, swap, res,
        output cur_col, cur_row, max_col, max_row, in_range
    );
endinterface

// ==== design/dww_addr_gen.sv ====
// column and row address counters of the write window
module dww_addr_gen
    import dww_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    dww_win_if.gen win
);

    dww_gen_type s_r;
    dww_gen_type s_nxt;
    logic [15:0] col_first;
    logic [15:0] col_last;
    logic [15:0] row_first;
    logic [15:0] row_last;

    // ----------------------------------------------------------------
    // limits and counters
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // column limit
        if (!win.swap) begin
            if (win.res == `DWW_RES_320X480) begin
                win.max_col = `DWW_MAX_319;
            end else begin
                win.max_col = `DWW_MAX_359;
            end
        end else if (win.res == `DWW_RES_360X640) begin
            win.max_col = `DWW_MAX_639;
        end else begin
            win.max_col = `DWW_MAX_479;
        end
        // row limit
        if (!win.swap) begin
            if (win.res == `DWW_RES_360X640) begin
                win.max_row = `DWW_MAX_639;
            end else begin
                win.max_row = `DWW_MAX_479;
            end
        end else if (win.res == `DWW_RES_320X480) begin
            win.max_row = `DWW_MAX_319;
        end else begin
            win.max_row = `DWW_MAX_359;
        end
        // scan direction picks the corner the stream starts from
        col_first = win.col_rev ? win.col_end : win.col_start;
        col_last = win.col_rev ? win.col_start : win.col_end;
        row_first = win.row_rev ? win.row_end : win.row_start;
        row_last = win.row_rev ? win.row_start : win.row_end;
        if (win.load) begin
            s_nxt.col = col_first;
            s_nxt.row = row_first;
        end else if (win.step) begin
            if (s_r.col == col_last) begin
                s_nxt.col = col_first;
                if (s_r.row == row_last) begin
                    s_nxt.row = row_first;
                end else if (win.row_rev) begin
                    s_nxt.row = s_r.row - 16'h0001;
                end else begin
                    s_nxt.row = s_r.row + 16'h0001;
                end
            end else if (win.col_rev) begin
                s_nxt.col = s_r.col - 16'h0001;
            end else begin
                s_nxt.col = s_r.col + 16'h0001;
            end
        end
        win.cur_col = s_r.col;
        win.cur_row = s_r.row;
        win.in_range = (s_r.col <= win.max_col) &&
            (s_r.row <= win.max_row);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== design/dww_top.sv ====
// command interpreter for panel blanking, access window and pixel writes
// Function
// - blank command stops showing memory and shows a blank page
// - show command resumes showing frame memory content
// - blank and show touch no memory and no other state; the code still records last_cmd and ends an open pixel stream or window parameter sequence
// - repeating blank or show has no further effect
// - after any reset the panel output is blanked
// - column window takes four bytes: start high, low, end high, low
// - row window takes four bytes: start high, low, end high, low
// - pixels outside the valid address range are discarded
// - column limit is 359, 319, 639 or 479 by resolution and swap
// - row limit is 639, 479, 359 or 319 by resolution and swap
// - pixel write command loads counters with window start
// - start corner follows the scan direction setting
// - each pixel is stored, then counters advance
// - any other command ends the pixel stream
// - pixel stream has no length limit
// - no memory access from pixel data while sleeping
//
// Added by the designer: the APB slave port and the register addresses.
module dww_top
    import dww_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic panel_blank,
    output logic mem_we,
    output logic [15:0] mem_col,
    output logic [15:0] mem_row,
    output logic [23:0] mem_data
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    dww_rst_type rst_r;
    dww_rst_type rst_nxt;
    logic rst_n;

    always_comb begin
        rst_nxt.rs = {rst_r.rs[0], 1'b1};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_r <= '0;
        end else begin
            rst_r <= rst_nxt;
        end
    end

    assign rst_n = rst_r.rs[1];

    // ----------------------------------------------------------------
    // address generator
    // ----------------------------------------------------------------
    dww_win_if win ();

    dww_addr_gen u_gen (
        .clk(clk),
        .rst_n(rst_n),
        .win(win)
    );

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    dww_top_type s_r;
    dww_top_type s_nxt;
    logic acc_first;
    logic do_wr;
    logic mapped;
    logic [7:0] wbyte;
    logic ld;
    logic st;
    logic sleeping;

    assign win.load = ld;
    assign win.step = st;
    assign win.col_start = s_r.col_start;
    assign win.col_end = s_r.col_end;
    assign win.row_start = s_r.row_start;
    assign win.row_end = s_r.row_end;
    assign win.col_rev = s_r.ctrl[`DWW_CTRL_COLREV];
    assign win.row_rev = s_r.ctrl[`DWW_CTRL_ROWREV];
    assign win.swap = s_r.ctrl[`DWW_CTRL_SWAP];
    assign win.res = s_r.ctrl[`DWW_CTRL_RES_LO +: 2];

    always_comb begin
        s_nxt = s_r;
        ld = 1'b0;
        st = 1'b0;
        wbyte = pwdata[7:0];
        sleeping = s_r.ctrl[`DWW_CTRL_SLEEP];
        acc_first = psel && penable && !s_r.pready;
        do_wr = psel && penable && pwrite && s_r.pready;
        case (paddr)
            `DWW_OFS_CMD,
            `DWW_OFS_PARAM,
            `DWW_OFS_PIXEL,
            `DWW_OFS_CTRL,
            `DWW_OFS_STATUS,
            `DWW_OFS_COLWIN,
            `DWW_OFS_ROWWIN,
            `DWW_OFS_POS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase

        // apb answer: one wait state, read data registered in the same cycle as pready
        s_nxt.pready = acc_first;
        s_nxt.pslverr = acc_first && !mapped;
        if (acc_first) begin
            case (paddr)
                `DWW_OFS_CMD: begin
                    s_nxt.prdata = {24'h000000, s_r.last_cmd};
                end
                `DWW_OFS_CTRL: begin
                    s_nxt.prdata = {26'h0000000, s_r.ctrl};
                end
                `DWW_OFS_STATUS: begin
                    s_nxt.prdata = 32'h00000000;
                    s_nxt.prdata[`DWW_STAT_SHOW] = s_r.show;
                    s_nxt.prdata[`DWW_STAT_STREAM] = s_r.mode == DWW_PIX;
                    s_nxt.prdata[`DWW_STAT_DROP] = s_r.dropped;
                end
                `DWW_OFS_COLWIN: begin
                    s_nxt.prdata = {s_r.col_end, s_r.col_start};
                end
                `DWW_OFS_ROWWIN: begin
                    s_nxt.prdata = {s_r.row_end, s_r.row_start};
                end
                `DWW_OFS_POS: begin
                    s_nxt.prdata = {win.cur_row, win.cur_col};
                end
                default: begin
                    s_nxt.prdata = 32'h00000000;
                end
            endcase
        end

        s_nxt.mem_we = 1'b0;

        if (do_wr) begin
            case (paddr)
                `DWW_OFS_CMD: begin
                    s_nxt.last_cmd = wbyte;
                    s_nxt.pidx = 2'h0;
                    s_nxt.mode = DWW_IDLE;
                    case (wbyte)
                        `DWW_CMD_BLANK: begin
                            s_nxt.show = 1'b0;
                        end
                        `DWW_CMD_SHOW: begin
                            s_nxt.show = 1'b1;
                        end
                        `DWW_CMD_COLWIN: begin
                            s_nxt.mode = DWW_COLP;
                        end
                        `DWW_CMD_ROWWIN: begin
                            s_nxt.mode = DWW_ROWP;
                        end
                        `DWW_CMD_PIXWR: begin
                            s_nxt.mode = DWW_PIX;
                            s_nxt.dropped = 1'b0;
                            ld = 1'b1;
                        end
                        `DWW_CMD_SWRESET: begin
                            s_nxt.show = 1'b0;
                            s_nxt.col_start = `DWW_ZERO16;
                            s_nxt.col_end = win.max_col;
                            s_nxt.row_start = `DWW_ZERO16;
                            s_nxt.row_end = win.max_row;
                        end
                        default: begin
                        end
                    endcase
                end
                `DWW_OFS_PARAM: begin
                    if (s_r.mode == DWW_COLP) begin
                        case (s_r.pidx)
                            2'h0: s_nxt.col_start[15:8] = wbyte;
                            2'h1: s_nxt.col_start[7:0] = wbyte;
                            2'h2: s_nxt.col_end[15:8] = wbyte;
                            default: s_nxt.col_end[7:0] = wbyte;
                        endcase
                    end else if (s_r.mode == DWW_ROWP) begin
                        case (s_r.pidx)
                            2'h0: s_nxt.row_start[15:8] = wbyte;
                            2'h1: s_nxt.row_start[7:0] = wbyte;
                            2'h2: s_nxt.row_end[15:8] = wbyte;
                            default: s_nxt.row_end[7:0] = wbyte;
                        endcase
                    end
                    if (s_r.mode == DWW_COLP || s_r.mode == DWW_ROWP) begin
                        s_nxt.pidx = s_r.pidx + 2'h1;
                        if (s_r.pidx == `DWW_PIDX_LAST) begin
                            s_nxt.mode = DWW_IDLE;
                        end
                    end
                end
                `DWW_OFS_PIXEL: begin
                    // stream stays open for any number of words
                    if (s_r.mode == DWW_PIX) begin
                        st = 1'b1;
                        if (win.in_range && !sleeping) begin
                            s_nxt.mem_we = 1'b1;
                            s_nxt.mem_data = pwdata[23:0];
                            if (win.swap) begin
                                s_nxt.mem_col = win.cur_row;
                                s_nxt.mem_row = win.cur_col;
                            end else begin
                                s_nxt.mem_col = win.cur_col;
                                s_nxt.mem_row = win.cur_row;
                            end
                        end else begin
                            s_nxt.dropped = 1'b1;
                        end
                    end
                end
                `DWW_OFS_CTRL: begin
                    s_nxt.ctrl = pwdata[`DWW_CTRL_W-1:0];
                end
                default: begin
                end
            endcase
        end
        s_nxt.panel_blank = !s_nxt.show;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.mode <= DWW_IDLE;
            s_r.pidx <= 2'h0;
            s_r.show <= 1'b0;
            s_r.col_start <= `DWW_ZERO16;
            s_r.col_end <= `DWW_MAX_359;
            s_r.row_start <= `DWW_ZERO16;
            s_r.row_end <= `DWW_MAX_639;
            s_r.ctrl <= `DWW_CTRL_RST;
            s_r.last_cmd <= 8'h00;
            s_r.dropped <= 1'b0;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.prdata <= 32'h00000000;
            s_r.panel_blank <= 1'b1;
            s_r.mem_we <= 1'b0;
            s_r.mem_col <= `DWW_ZERO16;
            s_r.mem_row <= `DWW_ZERO16;
            s_r.mem_data <= 24'h000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign panel_blank = s_r.panel_blank;
    assign mem_we = s_r.mem_we;
    assign mem_col = s_r.mem_col;
    assign mem_row = s_r.mem_row;
    assign mem_data = s_r.mem_data;

endmodule

// ==== sim/dww_host_model.sv ====
// host model issuing apb transfers
module dww_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // request held until pready sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== sim/dww_asserts.sv ====
// port checker of the display window write block
`include "dww_cfg.svh"
module dww_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic panel_blank,
    input wire logic mem_we,
    input wire logic [15:0] mem_col,
    input wire logic [15:0] mem_row,
    input wire logic [23:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic done;
    logic cmd_wr;
    assign done = psel && penable && pready;
    assign cmd_wr = done && pwrite && paddr == `DWW_OFS_CMD;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_ready_wait: assert property (psel && $rose(penable)
        |-> !pready ##1 pready) else $error("pready timing wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (done |-> pslverr ==
        (paddr > `DWW_OFS_POS || paddr[1:0] != 2'b00))
        else $error("pslverr wrong for address");
    a_we_range: assert property (mem_we |->
        mem_col <= `DWW_MAX_639 && mem_row <= `DWW_MAX_639)
        else $error("memory write outside address range");
    a_reset_blank: assert property ($rose(resetn) |-> panel_blank)
        else $error("panel not blank after reset");
    a_blank_cmd: assert property (cmd_wr &&
        pwdata[7:0] == `DWW_CMD_BLANK |-> ##[1:2] panel_blank)
        else $error("blank command not applied");
    a_show_cmd: assert property (cmd_wr &&
        pwdata[7:0] == `DWW_CMD_SHOW |-> ##[1:2] !panel_blank)
        else $error("show command not applied");
    a_blank_cause: assert property ($changed(panel_blank)
        |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("panel state changed without command");
    a_we_cause: assert property (mem_we |->
        $past(done && pwrite && paddr == `DWW_OFS_PIXEL)
        && mem_data == $past(pwdata[23:0]))
        else $error("memory write without pixel word");
    a_we_pulse: assert property (mem_we |=> !mem_we)
        else $error("memory strobe too long");
    a_cmd_no_we: assert property (cmd_wr |=> !mem_we)
        else $error("command caused memory write");
endmodule
bind dww_top dww_asserts u_asserts (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel_blank(panel_blank), .mem_we(mem_we),
    .mem_col(mem_col), .mem_row(mem_row), .mem_data(mem_data));

// ==== sim/dww_top_tb.sv ====
// self-checking bench of the display window write block
`include "dww_cfg.svh"
module dww_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, panel_blank, mem_we, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] seed = 32'hb7ab88a2;
    logic [15:0] mem_col, mem_row, cs, rs, m;
    logic [23:0] mem_data, d;
    logic [55:0] q[$];
    logic [55:0] x[8];
    int n_errors = 0;
    int checked = 0;
    int n;
    initial begin
        forever #2 clk = ~clk;
    end
    dww_top dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .panel_blank(panel_blank), .mem_we(mem_we),
        .mem_col(mem_col), .mem_row(mem_row), .mem_data(mem_data));
    dww_host_model h (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always @(posedge clk) begin
        if (mem_we === 1'b1) q.push_back({mem_col, mem_row, mem_data});
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // highest counter address for resolution and swap
    function automatic logic [15:0] lim(input logic [1:0] res,
        input logic sw, input logic row);
        if (sw ^ row) return res == 2'b00 ? 16'h027f : 16'h01df;
        return res == 2'b10 ? 16'h013f : 16'h0167;
    endfunction
    task automatic check(input string nm, input logic [55:0] sv, ev);
        checked++;
        if (sv !== ev) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] t;
        logic f;
        h.xfer(1'b1, a, v, t, f);
    endtask
    task automatic rd(input logic [7:0] a);
        h.xfer(1'b0, a, 32'h0, r, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(`DWW_OFS_CMD, {24'h0, c});
        repeat (2) @(negedge clk);
    endtask
    task automatic win(input logic [7:0] c, input logic [15:0] s, t);
        cmd(c);
        wr(`DWW_OFS_PARAM, {24'h0, s[15:8]});
        wr(`DWW_OFS_PARAM, {24'h0, s[7:0]});
        wr(`DWW_OFS_PARAM, {24'h0, t[15:8]});
        wr(`DWW_OFS_PARAM, {24'h0, t[7:0]});
    endtask
    task automatic pix();
        d = 24'(rnd());
        wr(`DWW_OFS_PIXEL, {8'h0, d});
        repeat (2) @(negedge clk);
    endtask
    initial begin
        #100us;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("blank", panel_blank, 1);
        for (int i = 0; i < 4; i++) begin
            cmd(i < 2 ? `DWW_CMD_BLANK : `DWW_CMD_SHOW);
            check("blank", panel_blank, i < 2);
            rd(`DWW_OFS_STATUS);
            check("status", r[0], i >= 2);
        end
        cs = 16'(rnd() % 300);
        rs = 16'(rnd() % 300);
        win(`DWW_CMD_COLWIN, cs, cs + 16'd2);
        win(`DWW_CMD_ROWWIN, rs, rs + 16'd1);
        rd(`DWW_OFS_COLWIN);
        check("colwin", r, {cs + 16'd2, cs});
        rd(`DWW_OFS_ROWWIN);
        check("rowwin", r, {rs + 16'd1, rs});
        q.delete();
        cmd(`DWW_CMD_PIXWR);
        for (int k = 0; k < 8; k++) begin
            pix();
            x[k] = {cs + 16'(k % 3), rs + 16'(k / 3 % 2), d};
        end
        check("count", q.size(), 8);
        foreach (x[k]) check("pixel", q[k], x[k]);
        cmd(`DWW_CMD_BLANK);
        pix();
        check("stopped", q.size(), 8);
        rd(`DWW_OFS_COLWIN);
        check("colwin", r, {cs + 16'd2, cs});
        wr(`DWW_OFS_CTRL, 32'h8);
        cmd(`DWW_CMD_PIXWR);
        pix();
        check("reverse", q[8], {cs + 16'd2, rs, d});
        wr(`DWW_OFS_CTRL, 32'h14);
        cmd(`DWW_CMD_PIXWR);
        for (int k = 0; k < 4; k++) begin
            pix();
            check("swap", q[9 + k], {rs + 16'd1 - 16'(k / 3),
                cs + 16'(k % 3), d});
        end
        wr(`DWW_OFS_CTRL, 32'h20);
        cmd(`DWW_CMD_PIXWR);
        pix();
        check("sleep", q.size(), 13);
        rd(`DWW_OFS_STATUS);
        check("status", r[2:0], 3'b110);
        for (int j = 0; j < 24; j++) begin
            m = lim(2'(j / 8), j[2], j[1]) + 16'(j[0]);
            wr(`DWW_OFS_CTRL, {29'h0, j[2], 2'(j / 8)});
            win(`DWW_CMD_COLWIN, j[1] ? 16'h0 : m, j[1] ? 16'h0 : m);
            win(`DWW_CMD_ROWWIN, j[1] ? m : 16'h0, j[1] ? m : 16'h0);
            n = q.size();
            cmd(`DWW_CMD_PIXWR);
            pix();
            check("limit", q.size() - n, !j[0]);
        end
        rd(8'h20);
        check("slverr", e, 1);
        cmd(`DWW_CMD_SHOW);
        check("blank", panel_blank, 0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("blank", panel_blank, 1);
        rd(`DWW_OFS_COLWIN);
        check("colwin", r, {16'h0167, 16'h0});
        end_sim();
    end
endmodule
